// ### verilog/agen_pkg.sv
// Purpose: shared types and constants for the segmented address generator
// Assumes: general registers numbered 0..7 in the usual order
// Notes:   segment selectors indexed 0..5
package agen_pkg;

  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned PHYS_W      = 24;
  localparam int unsigned OFS16_W     = 16;
  localparam int unsigned QUEUE_DEPTH = 16;
  localparam int unsigned NUM_GPR     = 8;
  localparam int unsigned NUM_SEG     = 6;

  // general register numbers
  localparam logic [2:0] REG_BX      = 3'h3;
  localparam logic [2:0] REG_STACK   = 3'h4;
  localparam logic [2:0] REG_FRAME   = 3'h5;
  localparam logic [2:0] REG_SI      = 3'h6;
  localparam logic [2:0] REG_DI      = 3'h7;

  // reset value and base+index extra cycle count
  localparam logic [31:0] RST_ADDR   = 32'h0000_0000;
  localparam logic [1:0]  BASE_INDEX_EXTRA_CYCLES = 2'h1;

  typedef enum logic [2:0] {
    SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA, SEG_SECOND, SEG_THIRD
  } seg_e;

  typedef enum logic [1:0] {
    REF_FETCH, REF_STACK, REF_STRING_DEST, REF_DATA
  } ref_e;

  typedef enum logic [1:0] {
    DISP_NONE, DISP_8, DISP_WIDE
  } disp_e;

  typedef enum logic [1:0] {
    SIZE_BYTE, SIZE_WORD, SIZE_DWORD
  } opsize_e;

  // one address request
  typedef struct packed {
    ref_e        kind;
    logic        has_base;
    logic [2:0]  base_sel;
    logic        has_index;
    logic [2:0]  index_sel;
    logic [1:0]  scale_log2;
    disp_e       disp_kind;
    logic [31:0] disp;
    logic [31:0] ip;
    logic        ovr_valid;
    seg_e        ovr_seg;
    logic        addr_len_pfx;
    logic        op_len_pfx;
    opsize_e     op_size;
    logic [1:0]  num_operands;
    logic [31:0] wdata;
  } agen_req_s;

  // one answer
  typedef struct packed {
    logic [23:0] phys_addr;
    logic [31:0] linear_addr;
    logic [31:0] offset;
    seg_e        seg;
    logic        addr16;
    logic        op16;
    logic [3:0]  byte_en;
    logic [31:0] lane_data;
    logic        bad_reg;
  } agen_rsp_s;

endpackage : agen_pkg

// ### verilog/byte_lane_placer.sv
// Purpose: place a value in adjacent byte locations, low byte first
// Assumes: bytes counted upward from the operand's own address
// Notes:   purely combinational
module byte_lane_placer
(
  // operand
  input  wire logic [31:0]     value,
  input  wire agen_pkg::opsize_e size,
  // placement
  output logic      [3:0]      byte_en,
  output logic      [31:0]     lanes
);

  always_comb
  begin
    lanes = value;                     // lane 0 = least significant
    case (size)
      agen_pkg::SIZE_BYTE:  byte_en = 4'h1;
      agen_pkg::SIZE_WORD:  byte_en = 4'h3;   // two adjacent bytes
      agen_pkg::SIZE_DWORD: byte_en = 4'hF;   // four adjacent bytes
      default:              byte_en = 4'h0;
    endcase
  end

endmodule // byte_lane_placer

// ### verilog/prefetch_queue.sv
// Purpose: instruction byte queue ahead of decoding
// Assumes: one byte in and one out per cycle at most
// Notes:   full blocks the writer; empty gives no valid byte
module prefetch_queue
#(
  parameter int unsigned DEPTH = agen_pkg::QUEUE_DEPTH
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // fill side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  output logic            in_ready,
  // drain side
  output logic            out_valid,
  output logic      [7:0] out_byte,
  input  wire logic       out_ready,
  input  wire logic       flush
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0]   count;
  } q_s;

  q_s         q_ff;
  q_s         nxt_q;
  logic [7:0] mem [DEPTH];
  logic       push;
  logic       pop;

  assign in_ready  = (q_ff.count != (PW+1)'(DEPTH));
  assign out_valid = (q_ff.count != '0);
  assign out_byte  = mem[q_ff.rd];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_comb
  begin
    nxt_q = q_ff;
    if (flush)
    begin
      nxt_q = '0;
    end
    else
    begin
      if (push) nxt_q.wr = q_ff.wr + PW'(1);
      if (pop)  nxt_q.rd = q_ff.rd + PW'(1);
      nxt_q.count = q_ff.count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset) q_ff <= '0;
    else       q_ff <= nxt_q;
  end

  // storage has no reset; count guards reads
  always_ff @(posedge clock)
  begin
    if (push) mem[q_ff.wr] <= in_byte;
  end

endmodule // prefetch_queue

// ### verilog/segmented_address_generator.sv
// Overview of operation
// - word stored low byte at lower address
// - dword stored four bytes, low byte first
// - operand address is its low byte
// - linear = segment base plus 32/16-bit offset
// - physical address is low 24 bits
// - defaults: fetch code, stack stack, data data
// - string destination always extra segment, no override
// - frame/stack base defaults stack, else data
// - override prefix replaces implied segment of data references only
// - offset = base + scaled index + displacement
// - 32-bit: index not stack pointer, scale 1-8
// - 16-bit: base bx/frame, index si/di, unscaled
// - displacement 8/16 or 8/32 bits by mode
// - base plus index costs one extra clock
// - 32-bit default; length prefixes select 16-bit
// - sixteen byte prefetch queue
// - 8/16/32-bit operands, zero to three each
//
// Purpose: operand address generation with segment selection
// Assumes: segment bases and general registers supplied by the core
// Notes:   answer registered; base+index adds one wait cycle
module segmented_address_generator
#(
  parameter int unsigned QDEPTH = agen_pkg::QUEUE_DEPTH
)
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // register file view
  input  wire logic [7:0][31:0]    gpr,
  input  wire logic [5:0][31:0]    seg_base,
  // request
  input  wire logic                req_valid,
  input  wire agen_pkg::agen_req_s req,
  output logic                     req_ready,
  // answer
  output logic                     rsp_valid,
  output agen_pkg::agen_rsp_s      rsp,
  // prefetch fill
  input  wire logic                pf_valid,
  input  wire logic [7:0]          pf_byte,
  output logic                     pf_ready,
  // prefetch drain
  output logic                     dq_valid,
  output logic      [7:0]          dq_byte,
  input  wire logic                dq_ready,
  input  wire logic                dq_flush
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXTRA} phase_e;

  typedef struct packed {
    phase_e              phase;
    agen_pkg::agen_rsp_s hold;
    logic                ready;
    logic                valid;
    agen_pkg::agen_rsp_s out;
  } state_s;

  state_s              st_ff;
  state_s              nxt_st;
  agen_pkg::agen_rsp_s calc;
  logic      [3:0]     lane_en;
  logic      [31:0]    lane_val;
  logic      [31:0]    base_val;
  logic      [31:0]    index_val;
  logic      [31:0]    disp_val;
  logic      [31:0]    ofs32;
  logic      [15:0]    ofs16;
  logic      [31:0]    offset;
  logic                addr16;
  logic                base_ok;
  logic                index_ok;
  logic                disp_ok;
  agen_pkg::seg_e      seg_sel;

  byte_lane_placer u_lanes
  (
    .value   (req.wdata),
    .size    (req.op_size),
    .byte_en (lane_en),
    .lanes   (lane_val)
  );

  prefetch_queue #(.DEPTH(QDEPTH)) u_queue
  (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (pf_valid),
    .in_byte   (pf_byte),
    .in_ready  (pf_ready),
    .out_valid (dq_valid),
    .out_byte  (dq_byte),
    .out_ready (dq_ready),
    .flush     (dq_flush)
  );

  assign addr16 = req.addr_len_pfx;

  // offset terms
  always_comb
  begin
    base_val  = req.has_base  ? gpr[req.base_sel]  : '0;
    index_val = req.has_index ? gpr[req.index_sel] : '0;
    case (req.disp_kind)
      agen_pkg::DISP_NONE: disp_val = '0;
      agen_pkg::DISP_8:    disp_val = {{24{req.disp[7]}}, req.disp[7:0]};
      agen_pkg::DISP_WIDE: disp_val = addr16 ?
                             {{16{req.disp[15]}}, req.disp[15:0]} : req.disp;
      default:             disp_val = '0;
    endcase
    // stack pointer as index is flagged bad; 16-bit mode limits both terms
    if (addr16)
    begin
      base_ok  = !req.has_base ||
                 req.base_sel == agen_pkg::REG_BX ||
                 req.base_sel == agen_pkg::REG_FRAME;
      index_ok = !req.has_index ||
                 req.index_sel == agen_pkg::REG_SI ||
                 req.index_sel == agen_pkg::REG_DI;
    end
    else
    begin
      base_ok  = 1'b1;
      index_ok = !req.has_index ||
                 req.index_sel != agen_pkg::REG_STACK;
    end
    disp_ok = req.disp_kind != 2'h3;
    // 32-bit scales by shift; 16-bit has none
    ofs32 = base_val + disp_val +
            (addr16 ? index_val : (index_val << req.scale_log2));
    ofs16 = ofs32[15:0];
    // fetches take the instruction pointer, never the operand terms
    if (req.kind == agen_pkg::REF_FETCH)
      offset = req.ip;
    else
      offset = addr16 ? {16'h0000, ofs16} : ofs32;
  end

  // segment choice
  always_comb
  begin
    case (req.kind)
      agen_pkg::REF_FETCH:       seg_sel = agen_pkg::SEG_CODE;
      agen_pkg::REF_STACK:       seg_sel = agen_pkg::SEG_STACK;
      agen_pkg::REF_STRING_DEST: seg_sel = agen_pkg::SEG_EXTRA;
      default:
      begin
        if (req.has_base && (req.base_sel == agen_pkg::REG_FRAME ||
            (!addr16 && req.base_sel == agen_pkg::REG_STACK)))
          seg_sel = agen_pkg::SEG_STACK;
        else
          seg_sel = agen_pkg::SEG_DATA;
        if (req.ovr_valid)
          seg_sel = req.ovr_seg;
      end
    endcase
  end

  // answer assembly
  always_comb
  begin
    calc             = '0;
    calc.offset      = offset;       // low-byte address of operand
    calc.seg         = seg_sel;
    calc.linear_addr = seg_base[seg_sel] + offset;
    calc.phys_addr   = calc.linear_addr[23:0];
    calc.addr16      = addr16;
    calc.op16        = req.op_len_pfx;
    calc.byte_en     = lane_en;
    calc.lane_data   = lane_val;
    calc.bad_reg     = !(base_ok && index_ok && disp_ok);
    if (req.op_len_pfx && req.op_size == agen_pkg::SIZE_DWORD)
      calc.byte_en   = 4'h3;
  end

  // phase control
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.valid = 1'b0;
    case (st_ff.phase)
      ST_IDLE:
      begin
        if (req_valid && st_ff.ready)
        begin
          if (req.has_base && req.has_index)
          begin
            nxt_st.hold  = calc;
            nxt_st.phase = ST_EXTRA;
            nxt_st.ready = 1'b0;
          end
          else
          begin
            nxt_st.out   = calc;
            nxt_st.valid = 1'b1;
          end
        end
      end
      ST_EXTRA:
      begin
        nxt_st.out   = st_ff.hold;
        nxt_st.valid = 1'b1;
        nxt_st.ready = 1'b1;
        nxt_st.phase = ST_IDLE;
      end
      default:
      begin
        nxt_st.phase = ST_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      st_ff       <= '0;
      st_ff.phase <= ST_IDLE;
      st_ff.ready <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready = st_ff.ready;
  assign rsp_valid = st_ff.valid;
  assign rsp       = st_ff.out;

endmodule // segmented_address_generator

// ### testbench/agen_asserts.sv
// Purpose: port-level checks on the segmented address generator
// Assumes: segment bases held steady while a request is in flight
// Notes:   bound into every instance of the top module
module agen_asserts
(
  // clock and reset
  input wire logic                clock,
  input wire logic                reset,
  // address path
  input wire logic [5:0][31:0]    seg_base,
  input wire logic                req_valid,
  input wire agen_pkg::agen_req_s req,
  input wire logic                req_ready,
  input wire logic                rsp_valid,
  input wire agen_pkg::agen_rsp_s rsp,
  // queue drain
  input wire logic                dq_valid,
  input wire logic [7:0]          dq_byte,
  input wire logic                dq_ready,
  input wire logic                dq_flush
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire take = req_valid && req_ready;
  wire pair = req.has_base && req.has_index;

  a_phys_trunc: assert property
    (rsp_valid |-> rsp.phys_addr == rsp.linear_addr[23:0])
    else $error("physical address not low linear bits");
  a_linear_sum: assert property
    (rsp_valid |-> rsp.linear_addr == seg_base[rsp.seg] + rsp.offset)
    else $error("linear address not base plus offset");
  a_short_wrap: assert property
    (rsp_valid && rsp.addr16 |-> rsp.offset[31:16] == 16'h0000)
    else $error("short offset not wrapped");
  a_single_lat: assert property
    (take && !pair |=> rsp_valid && req_ready)
    else $error("answer late without base and index");
  a_pair_lat: assert property
    (take && pair |=> !req_ready && !rsp_valid ##1 rsp_valid && req_ready)
    else $error("base plus index not one extra cycle");
  a_string_seg: assert property
    (take && !pair && req.kind == agen_pkg::REF_STRING_DEST
     |=> rsp.seg == agen_pkg::SEG_EXTRA)
    else $error("string destination not in extra segment");
  a_fetch_seg: assert property
    (take && !pair && req.kind == agen_pkg::REF_FETCH
     |=> rsp.seg == agen_pkg::SEG_CODE && rsp.offset == $past(req.ip))
    else $error("fetch not from code segment at ip");
  a_len_flags: assert property
    (take && !pair |=> rsp.addr16 == $past(req.addr_len_pfx)
     && rsp.op16 == $past(req.op_len_pfx))
    else $error("length flags do not follow prefixes");
  a_word_lanes: assert property
    (take && !pair && req.op_size == agen_pkg::SIZE_WORD
     |=> rsp.byte_en == 4'h3 && rsp.lane_data[15:0] == $past(req.wdata[15:0]))
    else $error("word not placed low byte first");
  a_drain_hold: assert property
    (dq_valid && !dq_ready && !dq_flush |=> dq_valid && $stable(dq_byte))
    else $error("queue head lost while stalled");
  a_flush_clear: assert property
    (dq_flush |=> !dq_valid && req_ready)
    else $error("flush did not empty the queue");
endmodule // agen_asserts

bind segmented_address_generator agen_asserts chk_i (.clock, .reset,
  .seg_base, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .dq_valid,
  .dq_byte, .dq_ready, .dq_flush);

// ### testbench/tb.sv
// Purpose: random and corner checks of the address generator
// Assumes: register views change only between requests
// Notes:   boundary register values provoke both wrap cases
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clock, reset, req_valid, req_ready, rsp_valid;
  logic [7:0][31:0]    gpr;
  logic [5:0][31:0]    seg_base;
  agen_pkg::agen_req_s req;
  agen_pkg::agen_rsp_s rsp;
  logic                pf_valid, pf_ready, dq_valid, dq_ready, dq_flush;
  logic [7:0]          pf_byte, dq_byte;
  int                  failures, tests_run;
  logic [7:0]          q[$];

  segmented_address_generator uut
  (
    .clock(clock), .reset(reset), .gpr(gpr), .seg_base(seg_base),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pf_valid(pf_valid),
    .pf_byte(pf_byte), .pf_ready(pf_ready), .dq_valid(dq_valid),
    .dq_byte(dq_byte), .dq_ready(dq_ready), .dq_flush(dq_flush)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // near-all-ones values force carries out of bit 15 and bit 31
  function automatic logic [31:0] pick();
    return ($urandom % 3 == 0) ? 32'hFFFF_FFF0 | 32'($urandom % 16) : $urandom;
  endfunction

  function automatic logic [31:0] exp_ofs(agen_pkg::agen_req_s r);
    logic [31:0] o;
    if (r.kind == agen_pkg::REF_FETCH)
      return r.ip;
    o = r.disp_kind == agen_pkg::DISP_8 ? {{24{r.disp[7]}}, r.disp[7:0]} :
        r.disp_kind == agen_pkg::DISP_WIDE ? r.disp : 32'h0000_0000;
    if (r.has_base)
      o += gpr[r.base_sel];
    if (r.has_index)
      o += gpr[r.index_sel] << (r.addr_len_pfx ? 0 : r.scale_log2);
    return r.addr_len_pfx ? {16'h0000, o[15:0]} : o;
  endfunction

  function automatic agen_pkg::seg_e exp_seg(agen_pkg::agen_req_s r);
    if (r.kind == agen_pkg::REF_FETCH)
      return agen_pkg::SEG_CODE;
    if (r.kind == agen_pkg::REF_STACK)
      return agen_pkg::SEG_STACK;
    if (r.kind == agen_pkg::REF_STRING_DEST)
      return agen_pkg::SEG_EXTRA;
    if (r.ovr_valid)
      return r.ovr_seg;
    if (r.has_base && (r.base_sel == agen_pkg::REG_FRAME ||
        (!r.addr_len_pfx && r.base_sel == agen_pkg::REG_STACK)))
      return agen_pkg::SEG_STACK;
    return agen_pkg::SEG_DATA;
  endfunction

  task automatic run(agen_pkg::agen_req_s r, logic bad);
    logic [31:0] o;
    logic [31:0] m;
    int          n;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= r;
    o = exp_ofs(r);
    m = r.op_size == agen_pkg::SIZE_BYTE ? 32'h0000_00FF :
        (r.op_size == agen_pkg::SIZE_WORD || r.op_len_pfx) ? 32'h0000_FFFF
        : 32'hFFFF_FFFF;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b0;
    do
    begin
      #1;
      n++;
      if (rsp_valid !== 1'b1 && n < 9)
        @(posedge clock);
    end
    while (rsp_valid !== 1'b1 && n < 9);
    if (n == 9)
    begin
      failures++;
      summarize();
    end
    chk("latency", (r.has_base && r.has_index) ? 2 : 1, n);
    chk("seg", exp_seg(r), rsp.seg);
    if (r.kind == agen_pkg::REF_FETCH || r.kind == agen_pkg::REF_DATA)
    begin
      chk("offset", o, rsp.offset);
      chk("phys", 32'(o + seg_base[exp_seg(r)]) & 32'h00FF_FFFF,
          rsp.phys_addr);
    end
    chk("byte_en", m == 32'h0000_00FF ? 4'h1 : m == 32'h0000_FFFF ? 4'h3
        : 4'hF, rsp.byte_en);
    chk("lanes", r.wdata & m, rsp.lane_data & m);
    chk("bad_reg", bad, rsp.bad_reg);
  endtask

  initial
  begin
    agen_pkg::agen_req_s r;
    {reset, req_valid, pf_valid, dq_ready, dq_flush} = 5'h10;
    {req, gpr, seg_base, pf_byte} = '0;
    {failures, tests_run} = '0;
    void'($urandom(29616));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (int t = 0; t < 300; t++)
    begin
      @(posedge clock);
      for (int i = 0; i < 8; i++)
        gpr[i] <= pick();
      for (int i = 0; i < 6; i++)
        seg_base[i] <= pick();
      r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      r.kind = agen_pkg::ref_e'($urandom % 4);
      r.disp_kind = agen_pkg::disp_e'($urandom % 3);
      r.ovr_seg = agen_pkg::seg_e'($urandom % 6);
      r.op_size = agen_pkg::opsize_e'($urandom % 3);
      r.index_sel = 3'($urandom % 7);
      if (r.index_sel >= agen_pkg::REG_STACK)
        r.index_sel++;
      if (r.addr_len_pfx)
      begin
        r.base_sel = r.base_sel[0] ? agen_pkg::REG_BX : agen_pkg::REG_FRAME;
        r.index_sel = r.index_sel[0] ? agen_pkg::REG_SI : agen_pkg::REG_DI;
      end
      if (r.kind == agen_pkg::REF_FETCH)
        {r.has_base, r.has_index, r.addr_len_pfx} = 3'h0;
      run(r, 1'b0);
    end
    // stack pointer as a 32-bit index is flagged
    r.kind = agen_pkg::REF_DATA;
    {r.has_base, r.has_index, r.addr_len_pfx} = 3'h2;
    r.index_sel = agen_pkg::REG_STACK;
    run(r, 1'b1);
    @(posedge clock);
    pf_valid <= 1'b1;
    pf_byte <= 8'($urandom);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clock);
      if (!pf_ready)
        break;
      q.push_back(pf_byte);
      pf_byte <= 8'($urandom);
    end
    pf_valid <= 1'b0;
    chk("fill", 16, q.size());
    dq_ready <= 1'b1;
    for (int i = 0; i < 40 && q.size() > 0; i++)
    begin
      @(posedge clock);
      if (dq_valid === 1'b1)
        chk("pop", q.pop_front(), dq_byte);
    end
    chk("drained", 0, q.size());
    @(posedge clock);
    chk("empty", 0, dq_valid);
    dq_ready <= 1'b0;
    pf_valid <= 1'b1;
    repeat (3) @(posedge clock);
    chk("filled", 1, dq_valid);
    pf_valid <= 1'b0;
    dq_flush <= 1'b1;
    @(posedge clock);
    dq_flush <= 1'b0;
    @(posedge clock);
    chk("flushed", 0, dq_valid);
    summarize();
  end
endmodule // tb
